// File: src/ubl_baud_gen.sv
`timescale 1ns/1ps
// fractional baud divider: one pulse per sample tick, one per bit period
module ubl_baud_gen
  import ubl_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  input  wire ubl_pkg::ubl_baud_cfg_t CFG,
  output logic                   SAMPLE_TICK,
  output logic                   BIT_TICK
);
  import ubl_pkg::*;
  typedef struct packed {
    logic [18:0] acc;  // divider in eighths
    logic [3:0]  ovs;  // sample counter
    logic        samp;
    logic        bit_t;
  } ubl_bg_st_t;
  ubl_bg_st_t st_reg, st_next;
  logic [18:0] step_lim; // divisor*8 + frac
  logic [3:0]  ovs_lim;

  // ************************************************************
  // sample divider: eighths accumulate up to divisor*8 + fraction
  // ************************************************************
  always_comb begin
    step_lim = {CFG.divisor, 3'b000} + {16'h0000, CFG.frac};
    ovs_lim  = CFG.over ? 4'(OVS_X8 - 1) : 4'(OVS_X16 - 1);
    st_next      = st_reg;
    st_next.samp  = 1'b0;
    st_next.bit_t = 1'b0;
    if (CFG.divisor == 16'h0000) begin
      // divisor zero stops the clock
      st_next.acc = '0;
      st_next.ovs = '0;
    end else if (st_reg.acc + 19'(FRAC_STEPS) >= step_lim) begin
      // carry the remainder so fractional steps average out
      st_next.acc  = st_reg.acc + 19'(FRAC_STEPS) - step_lim;
      st_next.samp = 1'b1;
      if (st_reg.ovs >= ovs_lim) begin
        st_next.ovs   = '0;
        st_next.bit_t = 1'b1;
      end else begin
        st_next.ovs = st_reg.ovs + 4'h1;
      end
    end else begin
      st_next.acc = st_reg.acc + 19'(FRAC_STEPS);
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign SAMPLE_TICK = st_reg.samp;
  assign BIT_TICK    = st_reg.bit_t;

  // ************************************************************
  // checks
  // ************************************************************
  a_bit_spacing: assert property (@(posedge CLK) disable iff (!RESET_N)
    (BIT_TICK && CFG.divisor == 16'h0004 && CFG.frac == 3'b000 && !CFG.over && $stable(CFG))
      |=> !BIT_TICK [*8])
    else $error("bit tick too early");
  a_zero_stop: assert property (@(posedge CLK) disable iff (!RESET_N)
    (CFG.divisor == 16'h0000) [*2] |-> !SAMPLE_TICK)
    else $error("tick with zero divisor");
  c_bit_tick: cover property (@(posedge CLK) disable iff (!RESET_N) BIT_TICK);
endmodule : ubl_baud_gen

// File: src/ubl_id_parity.sv
`timescale 1ns/1ps
// protected identifier: parity generation and check
module ubl_id_parity
  import ubl_pkg::*;
(
  input  wire logic       PDIS,
  input  wire logic [7:0] TX_ID,
  input  wire logic [7:0] RX_BYTE,
  output logic [7:0]      TX_BYTE,
  output logic [7:0]      RX_ID,
  output logic            RX_PERR
);
  import ubl_pkg::*;

  // parity over six identifier bits
  function automatic logic [1:0] id_par(input logic [5:0] id);
    id_par[0] = id[0] ^ id[1] ^ id[2] ^ id[4];
    id_par[1] = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
  endfunction : id_par

  // ************************************************************
  // transmit and receive paths
  // ************************************************************
  always_comb begin
    if (PDIS) begin
      TX_BYTE = TX_ID;
      RX_ID   = RX_BYTE;
      RX_PERR = 1'b0;
    end else begin
      TX_BYTE = {id_par(TX_ID[5:0]), TX_ID[5:0]};
      RX_ID   = {2'b00, RX_BYTE[5:0]};
      RX_PERR = id_par(RX_BYTE[5:0]) != RX_BYTE[7:6];
    end
  end
endmodule : ubl_id_parity

// File: src/ubl_pkg.sv
package ubl_pkg;
  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] BAUD_GEN_OFS  = 8'h00; // baud_gen_register
  localparam logic [7:0] LIN_MODE_OFS  = 8'h04; // lin_mode_register
  localparam logic [7:0] LIN_IDENT_OFS = 8'h08; // lin_identifier_register
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h0C; // sticky events, write one to clear
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h10; // interrupt enables
  localparam logic [7:0] LIN_CTRL_OFS  = 8'h14; // header start pulse
  // ************************************************************
  // field layout
  // ************************************************************
  localparam int BD_DIV_LSB  = 0;  // baud_divisor [15:0]
  localparam int BD_FRAC_LSB = 16; // fraction_part [18:16]
  localparam int BD_OVER_BIT = 19; // oversample select: 1 = x8
  localparam int LM_ACT_LSB  = 0;  // node_action_field [1:0]
  localparam int LM_PDIS_BIT = 2;  // id_parity_disable
  localparam int EV_PERR_BIT = 0;  // identifier parity error
  localparam int EV_IDTX_BIT = 1;  // identifier sent
  localparam int EV_IDRX_BIT = 2;  // identifier received
  localparam int EV_W        = 3;
  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [31:0] BAUD_GEN_RST = 32'h0000_0000;
  localparam logic [31:0] LIN_MODE_RST = 32'h0000_0000;
  localparam logic [7:0]  IDENT_RST    = 8'h00;
  localparam int          OVS_X16      = 16;
  localparam int          OVS_X8       = 8;
  localparam int          FRAC_STEPS   = 8;
  localparam int          FRAME_BITS   = 10; // start, 8 data, stop
  localparam int          CLK_MHZ      = 100;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {ACT_PUBLISH, ACT_SUBSCRIBE, ACT_IGNORE} ubl_node_act_t;
  // phase names kept apart from the indicator port names
  typedef enum logic [1:0] {PH_IDLE, PH_SEND, PH_RECV, PH_SKIP} ubl_rsp_t;
  typedef struct packed {
    logic [15:0] divisor;
    logic [2:0]  frac;
    logic        over;
  } ubl_baud_cfg_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ubl_byte_t;
endpackage : ubl_pkg

// File: src/ubl_top.sv
`timescale 1ns/1ps
// ************************************************************
// Functional notes
// - x16 integer mode: clock over 16 times divisor
// - fractional: clock over 8(2-over)(divisor+fraction/8)
// - identifier bits 0-5, parity bits 6-7
// - parity on: send computed parity, drop stored
// - parity on: bad received parity flags error
// - parity on: receive stores six bits only
// - parity off: all eight bits pass unchecked
// - node actions publish, subscribe, ignore
// - response phase follows node action after identifier
// ************************************************************
module ubl_top
  import ubl_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // axi4-lite slave
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  // serial link
  input  wire logic        LIN_RXD,
  output logic             LIN_TXD,
  // response phase indicators and interrupt
  output logic             RSP_SEND,
  output logic             RSP_RECV,
  output logic             IRQ
);
  import ubl_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} ubl_txs_t;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} ubl_rxs_t;
  typedef struct packed {
    logic            aw_got, w_got;  // write halves taken
    logic [7:0]      aw_addr;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
    logic [31:0]     baud_reg;       // baud_gen_register
    logic [31:0]     mode_reg;       // lin_mode_register
    logic [7:0]      ident_reg;      // identifier_char
    logic [EV_W-1:0] stat_reg;
    logic [EV_W-1:0] mask_reg;
    ubl_txs_t        txs;
    logic [3:0]      tx_cnt;         // bits left to shift
    logic [9:0]      tx_sh;
    logic            txd;
    ubl_rxs_t        rxs;
    logic [3:0]      rx_cnt;         // samples in bit
    logic [3:0]      rx_bits;
    logic [8:0]      rx_sh;
    ubl_rsp_t        rsp;
  } ubl_st_t;
  ubl_st_t st_reg, st_next;

  logic            rxd_s1, rxd_s2;   // pin synchroniser
  logic            samp_tick, bit_tick;
  ubl_baud_cfg_t   bcfg;
  logic [7:0]      tx_byte, rx_id, rx_raw;
  logic            rx_perr;
  logic            wr_fire;
  logic [EV_W-1:0] ev;
  logic [3:0]      half_smp;
  logic            act_pub, act_sub;
  logic            start_hdr;

  // ************************************************************
  // submodules
  // ************************************************************
  assign bcfg.divisor = st_reg.baud_reg[BD_DIV_LSB +: 16];
  assign bcfg.frac    = st_reg.baud_reg[BD_FRAC_LSB +: 3];
  assign bcfg.over    = st_reg.baud_reg[BD_OVER_BIT];

  ubl_baud_gen u_baud (
    .CLK         (CLK),
    .RESET_N     (RESET_N),
    .CFG         (bcfg),
    .SAMPLE_TICK (samp_tick),
    .BIT_TICK    (bit_tick)
  );

  // start bit sits in bit 0, data bits above it
  assign rx_raw = st_reg.rx_sh[8:1];
  ubl_id_parity u_par (
    .PDIS    (st_reg.mode_reg[LM_PDIS_BIT]),
    .TX_ID   (st_reg.ident_reg),
    .RX_BYTE (rx_raw),
    .TX_BYTE (tx_byte),
    .RX_ID   (rx_id),
    .RX_PERR (rx_perr)
  );

  // two flops on the receive pin
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
    end else begin
      rxd_s1 <= LIN_RXD;
      rxd_s2 <= rxd_s1;
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next  = st_reg;
    ev       = '0;
    wr_fire  = 1'b0;
    start_hdr = 1'b0;
    half_smp = st_reg.baud_reg[BD_OVER_BIT] ? 4'(OVS_X8 / 2 - 1) : 4'(OVS_X16 / 2 - 1);
    act_pub  = st_reg.mode_reg[LM_ACT_LSB +: 2] == ACT_PUBLISH;
    act_sub  = st_reg.mode_reg[LM_ACT_LSB +: 2] == ACT_SUBSCRIBE;
    // write address and data taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = S_AXI_WDATA;
      st_next.w_strb = S_AXI_WSTRB;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      wr_fire        = 1'b1;
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = 2'b00;
      case (st_reg.aw_addr)
        BAUD_GEN_OFS:  st_next.baud_reg = st_reg.w_data;
        LIN_MODE_OFS:  st_next.mode_reg = st_reg.w_data;
        LIN_IDENT_OFS: st_next.ident_reg = st_reg.w_data[7:0];
        IRQ_MASK_OFS:  st_next.mask_reg = st_reg.w_data[EV_W-1:0];
        LIN_CTRL_OFS:  start_hdr = st_reg.w_data[0];
        IRQ_STAT_OFS:  st_next.stat_reg = st_reg.stat_reg & ~st_reg.w_data[EV_W-1:0];
        default:       st_next.bresp = 2'b10; // unmapped: slave error
      endcase
    end
    if (st_reg.bvalid && S_AXI_BREADY) begin
      st_next.bvalid = 1'b0;
    end
    // read answer one cycle after address
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = 2'b00;
      case (S_AXI_ARADDR)
        BAUD_GEN_OFS:  st_next.rdata = st_reg.baud_reg;
        LIN_MODE_OFS:  st_next.rdata = st_reg.mode_reg;
        LIN_IDENT_OFS: st_next.rdata = {24'h00_0000, st_reg.ident_reg};
        IRQ_STAT_OFS:  st_next.rdata = {29'h0, st_reg.stat_reg};
        IRQ_MASK_OFS:  st_next.rdata = {29'h0, st_reg.mask_reg};
        LIN_CTRL_OFS:  st_next.rdata = {28'h0, 2'(st_reg.rsp), st_reg.rxs != RX_IDLE, st_reg.txs != TX_IDLE};
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = 2'b10;
        end
      endcase
    end else if (st_reg.rvalid && S_AXI_RREADY) begin
      st_next.rvalid = 1'b0;
    end
    // identifier transmit: start, byte, stop
    case (st_reg.txs)
      TX_IDLE: begin
        if (start_hdr) begin
          st_next.tx_sh  = {1'b1, tx_byte, 1'b0};
          st_next.tx_cnt = 4'(FRAME_BITS);
          st_next.txs    = TX_SHIFT;
          st_next.rsp    = PH_IDLE;
        end
      end
      TX_SHIFT: begin
        if (bit_tick) begin
          st_next.txd   = st_reg.tx_sh[0];
          st_next.tx_sh = {1'b1, st_reg.tx_sh[9:1]};
          st_next.tx_cnt = st_reg.tx_cnt - 4'h1;
          if (st_reg.tx_cnt == 4'h0) begin
            st_next.txd = 1'b1;
            st_next.txs = TX_IDLE;
            ev[EV_IDTX_BIT] = 1'b1;
          end
        end
      end
      default: st_next.txs = TX_IDLE;
    endcase
    // identifier receive, sampling mid bit
    case (st_reg.rxs)
      RX_IDLE: begin
        if (samp_tick && !rxd_s2 && st_reg.txs == TX_IDLE) begin
          st_next.rxs     = RX_SHIFT;
          st_next.rx_cnt  = 4'h0;
          st_next.rx_bits = 4'h0;
        end
      end
      RX_SHIFT: begin
        if (samp_tick) begin
          st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
          if (st_reg.rx_cnt == half_smp) begin
            st_next.rx_sh   = {rxd_s2, st_reg.rx_sh[8:1]};
            st_next.rx_bits = st_reg.rx_bits + 4'h1;
          end
          if (st_reg.rx_cnt == (st_reg.baud_reg[BD_OVER_BIT] ? 4'(OVS_X8 - 1) : 4'(OVS_X16 - 1))) begin
            st_next.rx_cnt = 4'h0;
            if (st_reg.rx_bits == 4'(FRAME_BITS - 1)) begin
              st_next.rxs = RX_IDLE;
            end
          end
        end
      end
      default: st_next.rxs = RX_IDLE;
    endcase
    // completed frame: start then 8 data bits in rx_sh, stop not waited for
    if (st_reg.rxs == RX_SHIFT && st_next.rxs == RX_IDLE) begin
      st_next.ident_reg = rx_id;
      ev[EV_IDRX_BIT]   = 1'b1;
      ev[EV_PERR_BIT]   = rx_perr;
    end
    // response phase chosen after the identifier
    if (ev[EV_IDTX_BIT] || ev[EV_IDRX_BIT]) begin
      st_next.rsp = act_pub ? PH_SEND : (act_sub ? PH_RECV : PH_SKIP);
    end
    // sticky events, set beats clear
    st_next.stat_reg = st_next.stat_reg | ev;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg          <= '0;
      st_reg.baud_reg <= BAUD_GEN_RST;
      st_reg.mode_reg <= LIN_MODE_RST;
      st_reg.ident_reg <= IDENT_RST;
      st_reg.txd      <= 1'b1;
      st_reg.txs      <= TX_IDLE;
      st_reg.rxs      <= RX_IDLE;
      st_reg.rsp      <= PH_IDLE;
      st_reg.rx_sh    <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign S_AXI_AWREADY = !st_reg.aw_got;
  assign S_AXI_WREADY  = !st_reg.w_got;
  assign S_AXI_BVALID  = st_reg.bvalid;
  assign S_AXI_BRESP   = st_reg.bresp;
  assign S_AXI_ARREADY = !st_reg.rvalid;
  assign S_AXI_RVALID  = st_reg.rvalid;
  assign S_AXI_RDATA   = st_reg.rdata;
  assign S_AXI_RRESP   = st_reg.rresp;
  assign LIN_TXD       = st_reg.txd;
  assign RSP_SEND      = st_reg.rsp == PH_SEND;
  assign RSP_RECV      = st_reg.rsp == PH_RECV;
  assign IRQ           = |(st_reg.stat_reg & st_reg.mask_reg);

  // ************************************************************
  // checks
  // ************************************************************
  a_rx_upper_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    ($rose(st_reg.stat_reg[EV_IDRX_BIT]) && !st_reg.mode_reg[LM_PDIS_BIT]) |-> st_reg.ident_reg[7:6] == 2'b00)
    else $error("upper identifier bits kept");
  a_perr_off: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_reg.mode_reg[LM_PDIS_BIT] && $stable(st_reg.stat_reg[EV_PERR_BIT]) == 1'b0) |-> !st_reg.mode_reg[LM_PDIS_BIT] || !st_reg.stat_reg[EV_PERR_BIT] || $past(st_reg.stat_reg[EV_PERR_BIT]) || !$past(st_reg.mode_reg[LM_PDIS_BIT]))
    else $error("parity error with parity off");
  a_tx_frame_len: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_reg.txs == TX_SHIFT && st_next.txs == TX_IDLE) |-> st_reg.tx_cnt == 4'h0 && LIN_TXD && st_reg.tx_sh == 10'h3FF)
    else $error("header frame length wrong");
  a_tx_parity: assert property (@(posedge CLK) disable iff (!RESET_N)
    (!st_reg.mode_reg[LM_PDIS_BIT]) |-> tx_byte[6] == (st_reg.ident_reg[0] ^ st_reg.ident_reg[1] ^ st_reg.ident_reg[2] ^ st_reg.ident_reg[4]))
    else $error("parity bit 6 wrong");
  a_rsp_follow: assert property (@(posedge CLK) disable iff (!RESET_N)
    ($rose(st_reg.stat_reg[EV_IDTX_BIT]) && $past(act_pub)) |-> RSP_SEND)
    else $error("response phase mismatch");
  a_irq_level: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_reg.stat_reg & st_reg.mask_reg) != '0 |-> IRQ)
    else $error("interrupt not raised");
  a_bresp_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
    (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID)
    else $error("write answer dropped");
  a_one_tx: assert property (@(posedge CLK) disable iff (!RESET_N)
    !(RSP_SEND && RSP_RECV))
    else $error("send and receive both set");
  c_hdr_tx: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(st_reg.stat_reg[EV_IDTX_BIT]));
  c_hdr_rx: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(st_reg.stat_reg[EV_IDRX_BIT]));
  c_perr:   cover property (@(posedge CLK) disable iff (!RESET_N) $rose(st_reg.stat_reg[EV_PERR_BIT]));
endmodule : ubl_top

// File: tb/ubl_lin_node.sv
`timescale 1ns/1ps
// ************************************************************
// remote node on the single-wire link
// ************************************************************
module ubl_lin_node (
  input  wire logic CLK,
  input  wire logic TXD,
  output logic      RXD
);
  int         bit_cyc = 64;   // clocks per bit, set by the bench
  logic       node_tx = 1'b1; // own driver, recessive high
  logic [7:0] rx_byte;        // last byte heard from the device
  longint     t_fall;         // start bit falling edge
  longint     t_rise;         // latest rising edge
  longint     rx_span;        // start fall to last rise, ns
  // wired-and bus with pull-up: either side pulls low
  assign RXD = node_tx & TXD;
  // last rising edge, for bit period measurement
  always @(posedge TXD) t_rise = $time;
  // frame receiver, samples at mid bit
  always begin
    @(negedge TXD);
    t_fall = $time;
    repeat (bit_cyc / 2) @(posedge CLK);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge CLK);
      rx_byte[i] = TXD;
    end
    repeat (bit_cyc) @(posedge CLK);
    rx_span = t_rise - t_fall;
  end
  // one frame: start, 8 bits lsb first, stop
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge CLK);
      node_tx <= f[i];
      repeat (bit_cyc - 1) @(posedge CLK);
    end
  endtask : send_byte
endmodule : ubl_lin_node

// File: tb/ubl_top_tb.sv
`timescale 1ns/1ps
module ubl_top_tb;
  import ubl_pkg::*;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0]      awa = 8'h00, ara = 8'h00;
  logic [31:0]     wd = 32'h0000_0000;
  wire logic       awr, wr_rdy, bv, arr, rv, txd, rxd, rs, rr, irq;
  wire logic [1:0] br, rrs;
  wire logic [31:0] rdat;
  int              fails = 0, n_checks = 0, cyc = 0, e;
  logic [31:0]     d;
  logic [1:0]      r;
  logic [31:0]     bcfg [3] = '{32'h0000_0004, 32'h0003_0005, 32'h000D_0006}; // x16, frac x16, frac x8
  logic [7:0]      ids [4] = '{8'hFF, 8'hC5, 8'h80, 8'h3A};
  // free running clock
  always #5 clk = ~clk;
  ubl_top i_ubl_top (.CLK(clk), .RESET_N(rst_n), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_BRESP(br),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rrs), .LIN_RXD(rxd), .LIN_TXD(txd),
    .RSP_SEND(rs), .RSP_RECV(rr), .IRQ(irq));
  ubl_lin_node i_ubl_lin_node (.CLK(clk), .TXD(txd), .RXD(rxd));
  // ************************************************************
  // bus tasks and helpers
  // ************************************************************
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= v; bry <= 1'b1;
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
      if (bv && bry) begin resp = br; bry <= 1'b0; break; end
    end
  endtask : wr
  // read: held until taken, data taken with rvalid
  task automatic rdr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    arv <= 1'b1; ara <= a; rry <= 1'b1;
    forever begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv && rry) begin v = rdat; resp = rrs; rry <= 1'b0; break; end
    end
  endtask : rdr
  // compare, exact or within a tolerance
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input int tol = 0);
    n_checks++;
    if (tol == 0 ? g !== x : (g > x + tol || g + tol < x)) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // poll the status register until an event bit is set
  task automatic wev(input int b);
    for (int k = 0; k < 3000; k++) begin
      rdr(IRQ_STAT_OFS, d, r);
      if (d[b] === 1'b1) break;
    end
  endtask : wev
  // protected identifier worked out by the bench
  function automatic logic [7:0] prot(input logic [5:0] i);
    prot = {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction : prot
  // send one header identifier and clear its event
  task automatic send_id(input logic [7:0] id, input logic [2:0] mode);
    i_ubl_lin_node.rx_byte = 8'hxx;
    wr(LIN_IDENT_OFS, {24'h00_0000, id}, r);
    wr(LIN_MODE_OFS, {29'h0000_0000, mode}, r);
    wr(LIN_CTRL_OFS, 32'h0000_0001, r);
    wev(EV_IDTX_BIT);
    wr(IRQ_STAT_OFS, 32'h0000_0007, r);
  endtask : send_id
  // ************************************************************
  // closing report
  // ************************************************************
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin fails++; complete_run(); end
  end
  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // reset values
    rdr(BAUD_GEN_OFS, d, r); chk(d, BAUD_GEN_RST);
    rdr(LIN_MODE_OFS, d, r); chk(d, LIN_MODE_RST);
    rdr(LIN_IDENT_OFS, d, r); chk(d, {24'h00_0000, IDENT_RST});
    // unmapped place refused
    wr(8'h18, 32'hFFFF_FFFF, r); chk(32'(r), 32'h0000_0002);
    rdr(8'h18, d, r); chk(32'(r), 32'h0000_0002); chk(d, 32'h0000_0000);
    // bit period for integer and fractional settings, parity off, ignore
    for (int i = 0; i < 3; i++) begin
      e = (OVS_X16 - (OVS_X16 - OVS_X8) * bcfg[i][BD_OVER_BIT]) * bcfg[i][15:0]
        + (2 - bcfg[i][BD_OVER_BIT]) * bcfg[i][18:16];
      i_ubl_lin_node.bit_cyc = e;
      wr(BAUD_GEN_OFS, bcfg[i], r);
      send_id(8'h55, 3'b110);
      chk({24'h00_0000, i_ubl_lin_node.rx_byte}, 32'h0000_0055);
      chk(32'(i_ubl_lin_node.rx_span), 9 * 10 * e, 20);
    end
    // parity on: computed parity sent, each node action in turn
    wr(BAUD_GEN_OFS, bcfg[0], r);
    i_ubl_lin_node.bit_cyc = 64;
    for (int n = 0; n < 4; n++) begin
      send_id(ids[n], {1'b0, n[1:0]});
      chk({24'h00_0000, i_ubl_lin_node.rx_byte}, {24'h00_0000, prot(ids[n][5:0])});
      chk({30'h0000_0000, rs, rr}, n == 0 ? 32'h0000_0002 : n == 1 ? 32'h0000_0001 : 32'h0);
      rdr(IRQ_STAT_OFS, d, r); chk(d, 32'h0000_0000);
      rdr(LIN_CTRL_OFS, d, r);
      chk(d, {28'h0, n == 0 ? 2'(PH_SEND) : n == 1 ? 2'(PH_RECV) : 2'(PH_SKIP), 2'b00});
    end
    // parity on receive, good parity, interrupt on id received
    wr(IRQ_MASK_OFS, 32'h0000_0004, r);
    rdr(IRQ_MASK_OFS, d, r); chk(d, 32'h0000_0004);
    wr(LIN_MODE_OFS, 32'h0000_0001, r);
    i_ubl_lin_node.send_byte(prot(6'h2A));
    wev(EV_IDRX_BIT); chk(d, 32'h0000_0004);
    chk(32'(irq), 32'h0000_0001);
    chk(32'(rr), 32'h0000_0001);
    rdr(LIN_IDENT_OFS, d, r); chk(d, 32'h0000_002A);
    wr(IRQ_MASK_OFS, 32'h0000_0000, r); chk(32'(irq), 32'h0000_0000);
    wr(IRQ_MASK_OFS, 32'h0000_0004, r); chk(32'(irq), 32'h0000_0001);
    wr(IRQ_STAT_OFS, 32'h0000_0007, r); chk(32'(irq), 32'h0000_0000);
    // parity on receive, bad parity flagged, six bits stored
    i_ubl_lin_node.send_byte(prot(6'h15) ^ 8'h40);
    wev(EV_IDRX_BIT); chk(d, 32'h0000_0005);
    rdr(LIN_IDENT_OFS, d, r); chk(d, 32'h0000_0015);
    wr(IRQ_STAT_OFS, 32'h0000_0007, r);
    // parity off receive, all eight bits stored unchecked
    wr(LIN_MODE_OFS, 32'h0000_0005, r);
    i_ubl_lin_node.send_byte(8'hEA);
    wev(EV_IDRX_BIT); chk(d, 32'h0000_0004);
    rdr(LIN_IDENT_OFS, d, r); chk(d, 32'h0000_00EA);
    complete_run();
  end
endmodule : ubl_top_tb
